// *** tb/rmcs_clk_src.sv ***
`timescale 1ns/10ps
// behavioural pll and oscillator sources
module rmcs_clk_src (
  input wire logic pll_power_down,  // pll off
  input wire logic osc_bypass,  // oscillator drives system
  output int pll_khz,  // pll output, zero when off
  output logic sys_from_pll  // system runs from pll
);
  import rmcs_pkg::*;
  // pll stops while powered down, else sits at target
  assign pll_khz = pll_power_down ? 0 : RMCS_PLL_TARGET_KHZ;
  // system runs from pll only when not bypassed and not powered down
  assign sys_from_pll = !osc_bypass && !pll_power_down;
endmodule

// *** tb/rmcs_monitor.sv ***
`timescale 1ns/10ps
// watches the top ports for clock select relations
module rmcs_monitor #(
  parameter int ALT_DIV_W = 6  // extended divisor width
) (
  input wire logic ref_clk,  // clock
  input wire logic rst_n,  // reset, active low
  input wire logic psel,  // select
  input wire logic penable,  // access phase
  input wire logic pwrite,  // direction
  input wire logic [rmcs_pkg::RMCS_ADDR_W-1:0] paddr,  // address
  input wire logic [31:0] pwdata,  // write data
  input wire logic [3:0] pstrb,  // strobes
  input wire logic [31:0] prdata,  // read data
  input wire logic pready,  // ready
  input wire logic pslverr,  // error
  input wire logic pll_power_down,  // pll off
  input wire logic osc_bypass,  // oscillator source
  input wire logic [3:0] crystal_frequency_select,  // crystal code
  input wire logic [rmcs_pkg::RMCS_FREQ_W-1:0] crystal_khz,  // crystal khz
  input wire logic [ALT_DIV_W-1:0] system_clock_divisor,  // divisor
  input wire logic divider_used,  // divider on
  input wire logic crystal_frequency_select_invalid  // bad code
);
  import rmcs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // decoded bus accesses
  wire wr_run = psel && penable && pwrite && paddr == RMCS_RCFG_ADDR;
  wire wr_ext = psel && penable && pwrite && paddr == RMCS_XCFG_ADDR && pstrb == 4'hF;
  wire rd_run = psel && penable && !pwrite && paddr == RMCS_RCFG_ADDR;
  logic [31:0] pw1;  // write data one edge back
  logic [31:0] pw2;  // write data two edges back
  // delay line, outputs land two edges after the write
  always_ff @(posedge ref_clk) begin
    pw1 <= pwdata;
    pw2 <= pw1;
  end
  ovr_div_a: assert property (wr_ext && pwdata[31] |-> ##2 system_clock_divisor == pw2[28:23])
    else $error("alternate divisor not used");
  pll_off_a: assert property (wr_run && pstrb[1] |-> ##2 pll_power_down == pw2[13])
    else $error("power down not following write");
  bypass_follow_a: assert property (wr_run && pstrb[1] |-> ##2 osc_bypass == pw2[11])
    else $error("bypass not following write");
  rsv_read_a: assert property (rd_run |-> prdata[21:14] == 8'h00 && prdata[12] && !prdata[10])
    else $error("reserved bits read wrong");
  crystal_frequency_select_inv_a: assert property (crystal_frequency_select_invalid == (!osc_bypass && crystal_frequency_select <= 4'h3))
    else $error("invalid crystal flag wrong");
  crystal_frequency_select_khz_a: assert property ($past(rst_n) && crystal_frequency_select == 4'hB |-> crystal_khz == 20'h01770)
    else $error("crystal frequency wrong");
  pll_div_a: assert property (!osc_bypass |-> divider_used)
    else $error("divider not forced with pll");
  crystal_frequency_select_hold_a: assert property (wr_run && pstrb[1:0] == 2'h3 |-> ##2 crystal_frequency_select == pw2[9:6])
    else $error("crystal code not held");
  // main scenarios
  cover property (wr_ext && pwdata[31]);
  cover property (rd_run);
  cover property (!osc_bypass && crystal_frequency_select_invalid);
endmodule

bind rmcs_top rmcs_monitor #(.ALT_DIV_W(ALT_DIV_W)) mon (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .pll_power_down, .osc_bypass, .crystal_frequency_select,
  .crystal_khz, .system_clock_divisor, .divider_used, .crystal_frequency_select_invalid);

// *** tb/rmcs_top_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module rmcs_top_bench;
  import rmcs_pkg::*;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;  // bus and reset
  logic [RMCS_ADDR_W-1:0] paddr = '0;  // address
  logic [31:0] pwdata = '0, prdata, rd;  // data
  logic [3:0] pstrb = 4'hF, crystal_frequency_select;  // strobes, code
  logic pready, pslverr, pll_power_down, osc_bypass, divider_used, crystal_frequency_select_invalid, sys_from_pll;  // outputs
  logic [RMCS_FREQ_W-1:0] crystal_khz;  // decoded khz
  logic [5:0] system_clock_divisor;  // divisor
  int fails = 0, total_checks = 0, cyc = 0, pll_khz;  // counters
  // expected khz of every crystal code
  logic [19:0] khz_tab [16] = '{20'h3E8, 20'h733, 20'h7D0, 20'h99A, 20'hDFC, 20'hE66, 20'hFA0, 20'h1000,
    20'h1333, 20'h1388, 20'h1400, 20'h1770, 20'h1800, 20'h1CCD, 20'h1F40, 20'h2000};
  rmcs_top dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pll_power_down, .osc_bypass, .crystal_frequency_select, .crystal_khz, .system_clock_divisor,
    .divider_used, .crystal_frequency_select_invalid);
  rmcs_clk_src src (.pll_power_down, .osc_bypass, .pll_khz, .sys_from_pll);
  // clock, 8 ns period
  initial forever #4 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic stop_test;
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      stop_test;
    end
  end
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let outputs follow the register
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // reset values of both words and outputs
  task automatic t_reset_vals;
    apb(0, RMCS_RCFG_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0780_3AD1)
    `CHK(err, 1'b0)
    `CHK(pll_khz, 0)
    `CHK({pll_power_down, osc_bypass, crystal_frequency_select}, 6'h3B)
    `CHK({divider_used, system_clock_divisor, crystal_khz}, 27'h0F_01770)
    apb(0, RMCS_XCFG_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0780_0000)
  endtask
  // pll selected, reserved bits written inverted (21:14,10 as ones, 12 as zero); keeps the system on the pll
  task automatic t_pll;
    apb(1, RMCS_RCFG_ADDR, 32'hF1BF_C58C, 4'hF);
    settle;
    apb(0, RMCS_RCFG_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0180_1180)
    `CHK({pll_power_down, osc_bypass, divider_used, sys_from_pll}, 4'h3)
    `CHK(system_clock_divisor, 6'h03)
    `CHK(pll_khz, RMCS_PLL_TARGET_KHZ)
  endtask
  // every crystal code with the pll, then a low code on the oscillator
  task automatic t_crystal_frequency_select;
    for (int c = 0; c < 16; c++) begin
      apb(1, RMCS_RCFG_ADDR, 32'h0180_0000 | (32'(c) << 6), 4'hF);
      settle;
      `CHK(crystal_khz, khz_tab[c])
      `CHK(crystal_frequency_select_invalid, 1'(c < 4))
    end
    apb(1, RMCS_RCFG_ADDR, 32'h0180_0880, 4'hF);
    settle;
    `CHK({crystal_frequency_select_invalid, divider_used}, 2'h0)
  endtask
  // override picks the extended divisor, clearing it returns
  task automatic t_ovr;
    apb(1, RMCS_XCFG_ADDR, 32'h9500_0000, 4'hF);
    settle;
    `CHK(system_clock_divisor, 6'h2A)
    apb(0, RMCS_STAT_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0000_002A)
    apb(0, RMCS_XCFG_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h9500_0000)
    apb(1, RMCS_XCFG_ADDR, 32'h1500_0000, 4'hF);
    settle;
    `CHK(system_clock_divisor, 6'h03)
  endtask
  // single byte lane write, then an unmapped access
  task automatic t_lane_bad;
    apb(1, RMCS_RCFG_ADDR, 32'h0000_2000, 4'h2);
    settle;
    `CHK({pll_power_down, osc_bypass, crystal_frequency_select, crystal_frequency_select_invalid}, 7'h45)
    apb(1, 12'h100, 32'hFFFF_FFFF, 4'hF);
    `CHK(err, 1'b1)
    apb(0, 12'h100, 32'h0, 4'hF);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(0, RMCS_RCFG_ADDR, 32'h0, 4'hF);
    `CHK(rd, 32'h0180_3080)
  endtask
  // reset in mid run restores defaults
  task automatic t_mid_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK({pll_power_down, osc_bypass, crystal_frequency_select, crystal_khz}, 26'h3B_01770)
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_vals;
    t_pll;
    t_crystal_frequency_select;
    t_ovr;
    t_lane_bad;
    t_mid_reset;
    stop_test;
  end
endmodule

// *** verilog/rmcs_crystal_frequency_select_lut.sv ***
`timescale 1ns/10ps
// maps a crystal select code to the crystal frequency in khz, rounded
module rmcs_crystal_frequency_select_lut (
  input wire logic [3:0] code,            // crystal select code
  output logic [rmcs_pkg::RMCS_FREQ_W-1:0] freq_khz  // crystal frequency in khz
);
  import rmcs_pkg::*;
  // code to frequency table
  always_comb begin
    case (code)
      4'h0: freq_khz = 20'h003E8;  // 1.000 mhz
      4'h1: freq_khz = 20'h00733;  // 1.8432 mhz
      4'h2: freq_khz = 20'h007D0;  // 2.000 mhz
      4'h3: freq_khz = 20'h0099A;  // 2.4576 mhz, rounded up
      4'h4: freq_khz = 20'h00DFC;  // 3.579545 mhz
      4'h5: freq_khz = 20'h00E66;  // 3.6864 mhz
      4'h6: freq_khz = 20'h00FA0;  // 4 mhz
      4'h7: freq_khz = 20'h01000;  // 4.096 mhz
      4'h8: freq_khz = 20'h01333;  // 4.9152 mhz
      4'h9: freq_khz = 20'h01388;  // 5 mhz
      4'hA: freq_khz = 20'h01400;  // 5.12 mhz
      4'hB: freq_khz = 20'h01770;  // 6 mhz
      4'hC: freq_khz = 20'h01800;  // 6.144 mhz
      4'hD: freq_khz = 20'h01CCD;  // 7.3728 mhz
      4'hE: freq_khz = 20'h01F40;  // 8 mhz
      default: freq_khz = 20'h02000;  // 8.192 mhz
    endcase
  end
endmodule

// *** verilog/rmcs_div_pick.sv ***
`timescale 1ns/10ps
// chooses the divisor and whether the divider is applied
module rmcs_div_pick #(
  parameter int DIV_W = 6  // width of the widest divisor field
) (
  input wire logic override,              // alternate config override
  input wire logic [3:0] prim_div,        // primary divisor field
  input wire logic [DIV_W-1:0] alt_div,   // alternate divisor field
  input wire logic use_div,               // divider use control
  input wire logic bypass,                // one: oscillator drives system
  output logic [DIV_W-1:0] div_sel,       // divisor in effect
  output logic div_apply                  // divider in use
);
  // refuse a divisor narrower than the primary field
  if (DIV_W < 4) begin : g_bad_width
    $error("divisor width too small");
  end
  // pick the divisor and force the divider while the pll is used
  always_comb begin
    div_sel = override ? alt_div : DIV_W'(prim_div);
    div_apply = use_div | ~bypass;
  end
endmodule

// *** verilog/rmcs_pkg.sv ***
package rmcs_pkg;
  // byte addresses of the two configuration words and the status word on the apb bus
  localparam logic [11:0] RMCS_RCFG_ADDR = 12'h060;  // run_clock_configuration
  localparam logic [11:0] RMCS_XCFG_ADDR = 12'h070;  // extended_run_clock_configuration
  localparam logic [11:0] RMCS_STAT_ADDR = 12'h074;  // resolved clock status, read only
  localparam int RMCS_ADDR_W = 12;
  // run_clock_configuration field positions
  localparam int RMCS_ACG_BIT = 27;
  localparam int RMCS_PRIMDIV_LSB = 23;  // primary divisor field
  localparam int RMCS_PRIMDIV_W = 4;
  localparam int RMCS_USEDIV_BIT = 22;
  localparam int RMCS_RSV_HI_MSB = 21;
  localparam int RMCS_RSV_HI_LSB = 14;
  localparam int RMCS_PLLOFF_BIT = 13;  // pll power down control
  localparam int RMCS_RSV12_BIT = 12;
  localparam int RMCS_BYPASS_BIT = 11;
  localparam int RMCS_RSV10_BIT = 10;
  localparam int RMCS_CRYSTAL_FREQUENCY_SELECT_LSB = 6;
  localparam int RMCS_CRYSTAL_FREQUENCY_SELECT_W = 4;
  localparam int RMCS_OSCSRC_LSB = 4;
  localparam int RMCS_OSCSRC_W = 2;
  localparam int RMCS_IOSCDIS_BIT = 1;
  localparam int RMCS_MOSCDIS_BIT = 0;
  // extended register field positions
  localparam int RMCS_OVR_BIT = 31;
  localparam int RMCS_ALTDIV_LSB = 23;
  localparam int RMCS_ALTDIV_W = 6;
  // status word field positions
  localparam int RMCS_STAT_APPLY_BIT = 8;  // divider in use
  localparam int RMCS_STAT_INV_BIT = 9;    // reserved crystal code with pll
  // reset values
  localparam logic [31:0] RMCS_RCFG_RESET = 32'h0780_3AD1;
  localparam logic [31:0] RMCS_XCFG_RESET = 32'h0780_0000;
  // crystal codes
  localparam logic [3:0] RMCS_CRYSTAL_FREQUENCY_SELECT_MAX_RSV = 4'h3;   // highest code not allowed with the pll
  localparam logic [3:0] RMCS_CRYSTAL_FREQUENCY_SELECT_RESET = 4'hB;
  // crystal frequency, in khz, of the reset code; pll target in khz
  localparam int RMCS_PLL_TARGET_KHZ = 400000;
  localparam int RMCS_FREQ_W = 20;
  localparam logic [RMCS_FREQ_W-1:0] RMCS_CRYSTAL_FREQUENCY_SELECT_RESET_KHZ = 20'h01770;  // 6 mhz, the reset crystal code
endpackage

// *** verilog/rmcs_top.sv ***
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - override bit selects extended divisor field
// - bit 13 drives pll power down
// - bit 11 picks oscillator or divided pll
// - bits 21:14,10 read zero, 12 one
// - crystal field resets 0xB, low codes bad
// - crystal codes map to listed frequencies
// - pll aims at 400 mhz from crystal
// - pll selected forces divider use
module rmcs_top #(
  parameter int ALT_DIV_W = 6  // width of the extended divisor field
) (
  input wire logic ref_clk,                 // system clock, 125 mhz
  input wire logic rst_n,                   // asynchronous reset, active low
  input wire logic psel,                    // apb select
  input wire logic penable,                 // apb access phase
  input wire logic pwrite,                  // apb direction, high writes
  input wire logic [rmcs_pkg::RMCS_ADDR_W-1:0] paddr,  // apb byte address
  input wire logic [31:0] pwdata,           // apb write data
  input wire logic [3:0] pstrb,             // apb byte strobes
  output logic [31:0] prdata,               // apb read data
  output logic pready,                      // apb ready
  output logic pslverr,                     // apb error on unmapped address
  output logic pll_power_down,              // to pll power down input
  output logic osc_bypass,                  // one: oscillator clocks system
  output logic [3:0] crystal_frequency_select,  // crystal code to clock logic
  output logic [rmcs_pkg::RMCS_FREQ_W-1:0] crystal_khz,  // decoded crystal frequency
  output logic [ALT_DIV_W-1:0] system_clock_divisor,  // divisor in effect
  output logic divider_used,                // system divider applied
  output logic crystal_frequency_select_invalid                 // reserved crystal code with pll in use
);
  import rmcs_pkg::*;

  // the extended field must hold the primary divisor and fit below bit 31
  if (ALT_DIV_W < RMCS_PRIMDIV_W || ALT_DIV_W > 8) begin : g_bad_width
    $error("bad extended divisor width");
  end

  logic [31:0] rcfg_r;      // run_clock_configuration storage
  logic [31:0] xcfg_r;      // extended_run_clock_configuration storage
  logic [31:0] rcfg_view;   // run config as software reads it
  logic [31:0] xcfg_view;   // extended config as software reads it
  logic [31:0] stat_view;   // status word
  logic [31:0] wmask;       // byte lanes enabled by strobes
  logic [31:0] rcfg_nxt;    // merged run config write
  logic [31:0] xcfg_nxt;    // merged extended config write
  logic wr_acc;             // write access phase
  logic rd_acc;             // read access phase
  logic addr_hit;           // address maps to a register
  logic [ALT_DIV_W-1:0] div_sel;  // chosen divisor
  logic div_apply;          // divider in use
  logic [RMCS_FREQ_W-1:0] crystal_frequency_select_khz;  // lut result

  // apb decode; every access completes in its first access cycle
  always_comb begin
    wr_acc = psel & penable & pwrite;
    rd_acc = psel & penable & ~pwrite;
    addr_hit = (paddr == RMCS_RCFG_ADDR) || (paddr == RMCS_XCFG_ADDR) || (paddr == RMCS_STAT_ADDR);
    pready = psel & penable;
    pslverr = psel & penable & ~addr_hit;
  end

  // expand byte strobes to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // build read views: reserved bits are forced on read; the stored words keep what was written
  always_comb begin
    rcfg_view = 32'h0000_0000;
    rcfg_view[RMCS_ACG_BIT] = rcfg_r[RMCS_ACG_BIT];
    rcfg_view[RMCS_PRIMDIV_LSB +: RMCS_PRIMDIV_W] = rcfg_r[RMCS_PRIMDIV_LSB +: RMCS_PRIMDIV_W];
    rcfg_view[RMCS_USEDIV_BIT] = rcfg_r[RMCS_USEDIV_BIT];
    rcfg_view[RMCS_RSV_HI_MSB:RMCS_RSV_HI_LSB] = 8'h00;
    rcfg_view[RMCS_PLLOFF_BIT] = rcfg_r[RMCS_PLLOFF_BIT];
    rcfg_view[RMCS_RSV12_BIT] = 1'b1;
    rcfg_view[RMCS_BYPASS_BIT] = rcfg_r[RMCS_BYPASS_BIT];
    rcfg_view[RMCS_RSV10_BIT] = 1'b0;
    rcfg_view[RMCS_CRYSTAL_FREQUENCY_SELECT_LSB +: RMCS_CRYSTAL_FREQUENCY_SELECT_W] = rcfg_r[RMCS_CRYSTAL_FREQUENCY_SELECT_LSB +: RMCS_CRYSTAL_FREQUENCY_SELECT_W];
    rcfg_view[RMCS_OSCSRC_LSB +: RMCS_OSCSRC_W] = rcfg_r[RMCS_OSCSRC_LSB +: RMCS_OSCSRC_W];
    rcfg_view[RMCS_IOSCDIS_BIT] = rcfg_r[RMCS_IOSCDIS_BIT];
    rcfg_view[RMCS_MOSCDIS_BIT] = rcfg_r[RMCS_MOSCDIS_BIT];
    xcfg_view = 32'h0000_0000;
    xcfg_view[RMCS_OVR_BIT] = xcfg_r[RMCS_OVR_BIT];
    xcfg_view[RMCS_ALTDIV_LSB +: ALT_DIV_W] = xcfg_r[RMCS_ALTDIV_LSB +: ALT_DIV_W];
    stat_view = 32'h0000_0000;
    stat_view[ALT_DIV_W-1:0] = div_sel;
    stat_view[RMCS_STAT_APPLY_BIT] = div_apply;
    stat_view[RMCS_STAT_INV_BIT] = crystal_frequency_select_invalid;
  end

  // merge write data into the stored words under strobes
  always_comb begin
    rcfg_nxt = (rcfg_r & ~wmask) | (pwdata & wmask);
    xcfg_nxt = (xcfg_r & ~wmask) | (pwdata & wmask);
  end

  // run config register; holds last write, reset to documented value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcfg_r <= RMCS_RCFG_RESET;
    end else if (wr_acc && paddr == RMCS_RCFG_ADDR) begin
      rcfg_r <= rcfg_nxt;
    end
  end

  // extended config register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xcfg_r <= RMCS_XCFG_RESET;
    end else if (wr_acc && paddr == RMCS_XCFG_ADDR) begin
      xcfg_r <= xcfg_nxt;
    end
  end

  // read data register; loaded in the read setup phase, zero on unmapped, held otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        RMCS_RCFG_ADDR: prdata <= rcfg_view;
        RMCS_XCFG_ADDR: prdata <= xcfg_view;
        RMCS_STAT_ADDR: prdata <= stat_view;
        default: prdata <= 32'h0000_0000;
      endcase
    end else if (rd_acc) begin
      prdata <= prdata;  // hold through access
    end
  end

  // divisor selection and forced divider
  rmcs_div_pick #(
    .DIV_W(ALT_DIV_W)
  ) u_div (
    .override(xcfg_r[RMCS_OVR_BIT]),
    .prim_div(rcfg_r[RMCS_PRIMDIV_LSB +: RMCS_PRIMDIV_W]),
    .alt_div(xcfg_r[RMCS_ALTDIV_LSB +: ALT_DIV_W]),
    .use_div(rcfg_r[RMCS_USEDIV_BIT]),
    .bypass(rcfg_r[RMCS_BYPASS_BIT]),
    .div_sel(div_sel),
    .div_apply(div_apply)
  );

  // crystal code decode for the pll translation, which aims at 400 mhz
  rmcs_crystal_frequency_select_lut u_lut (
    .code(rcfg_r[RMCS_CRYSTAL_FREQUENCY_SELECT_LSB +: RMCS_CRYSTAL_FREQUENCY_SELECT_W]),
    .freq_khz(crystal_frequency_select_khz)
  );

  // pll power down output; reset keeps the pll off until software clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_power_down <= RMCS_RCFG_RESET[RMCS_PLLOFF_BIT];  // pll off from reset
    end else begin
      pll_power_down <= rcfg_r[RMCS_PLLOFF_BIT];
    end
  end

  // system clock source; reset runs the system from the oscillator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_bypass <= RMCS_RCFG_RESET[RMCS_BYPASS_BIT];  // oscillator from reset
    end else begin
      osc_bypass <= rcfg_r[RMCS_BYPASS_BIT];
    end
  end

  // crystal code handed to the clock logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_frequency_select <= RMCS_CRYSTAL_FREQUENCY_SELECT_RESET;  // reset code
    end else begin
      crystal_frequency_select <= rcfg_r[RMCS_CRYSTAL_FREQUENCY_SELECT_LSB +: RMCS_CRYSTAL_FREQUENCY_SELECT_W];
    end
  end

  // decoded crystal frequency; reset value matches the reset code so no step follows reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_khz <= RMCS_CRYSTAL_FREQUENCY_SELECT_RESET_KHZ;  // khz of the reset code
    end else begin
      crystal_khz <= crystal_frequency_select_khz;
    end
  end

  // divisor in effect; reset value is the primary field's reset value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_clock_divisor <= ALT_DIV_W'(RMCS_RCFG_RESET[RMCS_PRIMDIV_LSB +: RMCS_PRIMDIV_W]);  // override off
    end else begin
      system_clock_divisor <= div_sel;
    end
  end

  // divider use, forced while the pll drives the system
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_used <= RMCS_RCFG_RESET[RMCS_USEDIV_BIT] | ~RMCS_RCFG_RESET[RMCS_BYPASS_BIT];  // reset fields
    end else begin
      divider_used <= div_apply;
    end
  end

  // flag reserved crystal codes while the pll feeds the system
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_frequency_select_invalid <= 1'b0;  // oscillator in use from reset
    end else begin
      crystal_frequency_select_invalid <= ~rcfg_r[RMCS_BYPASS_BIT] &
        (rcfg_r[RMCS_CRYSTAL_FREQUENCY_SELECT_LSB +: RMCS_CRYSTAL_FREQUENCY_SELECT_W] <= RMCS_CRYSTAL_FREQUENCY_SELECT_MAX_RSV);
    end
  end
endmodule
